// [hdl/dbm_dev.sv]
/*
 Device end of the data phase: places read words onto the lanes framed by
 the strobe, and gathers written bytes with their masks into words.
 Assumes the command phase logic, on mclk, pulses lat_done once latency
 has run out and holds space_select, xfer_write and zero_lat meanwhile.
 Bus clock, select, lanes and strobe arrive asynchronously.
*/
`timescale 1ns/1ns
module dbm_dev (
    input wire logic mclk,
    input wire logic arst_n,
    dbm_link_if.dev link,
    input wire logic lat_done,
    input wire logic xfer_write,
    input wire logic zero_lat,
    input wire logic space_select,
    input wire logic [dbm_pkg::WORD_W-1:0] rd_word,
    output logic rd_take,
    output logic [dbm_pkg::WORD_W-1:0] wr_word,
    output logic [1:0] wr_be,
    output logic wr_valid,
    output logic reg_space,
    output logic active
);
    import dbm_pkg::*;

    logic [DEV_SYNC_W-1:0] s1_reg;
    logic [DEV_SYNC_W-1:0] s2_reg;
    logic clk_d_reg;
    logic clk_s;
    logic sel_s;
    logic sm_s;
    logic [BYTE_W-1:0] dq_s;
    logic rise;
    logic fall;

    dbm_dev_state_t state_reg;
    dbm_dev_state_t state_next;
    logic zl_reg;
    logic zl_next;
    logic space_reg;
    logic space_next;
    logic active_reg;
    logic active_next;
    logic [BYTE_W-1:0] b_hold_reg;
    logic [BYTE_W-1:0] b_hold_next;
    logic [BYTE_W-1:0] a_reg;
    logic [BYTE_W-1:0] a_next;
    logic ma_reg;
    logic ma_next;
    logic [BYTE_W-1:0] dq_reg;
    logic [BYTE_W-1:0] dq_next;
    logic dq_oe_reg;
    logic dq_oe_next;
    logic sm_reg;
    logic sm_next;
    logic sm_oe_reg;
    logic sm_oe_next;
    logic rd_take_reg;
    logic rd_take_next;
    logic [WORD_W-1:0] wr_word_reg;
    logic [WORD_W-1:0] wr_word_next;
    logic [1:0] wr_be_reg;
    logic [1:0] wr_be_next;
    logic wr_valid_reg;
    logic wr_valid_next;

    // Two-stage synchroniser; only the second stage feeds any logic
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // Both stages start at idle levels, so no false select follows
            s1_reg <= {1'h0, 1'h1, 1'h0, DQ_IDLE};
            s2_reg <= {1'h0, 1'h1, 1'h0, DQ_IDLE};
            clk_d_reg <= 1'h0;
        end else begin
            s1_reg <= {link.bus_clk, link.sel_n, link.strobe_mask, link.dq};
            s2_reg <= s1_reg;
            clk_d_reg <= s2_reg[DEV_SYNC_W-1];
        end
    end

    // Lanes and clock share one sync path, so data seen at an edge is the
    // data that stood at that edge; this only holds because the host moves
    // lanes mid-way between edges
    assign clk_s = s2_reg[DEV_SYNC_W-1];
    assign sel_s = s2_reg[DEV_SYNC_W-2];
    assign sm_s = s2_reg[BYTE_W];
    assign dq_s = s2_reg[BYTE_W-1:0];
    assign rise = clk_s & ~clk_d_reg;
    assign fall = ~clk_s & clk_d_reg;

    // Data phase sequencing and lane placement
    always_comb begin
        state_next = state_reg;
        zl_next = zl_reg;
        space_next = space_reg;
        active_next = active_reg;
        b_hold_next = b_hold_reg;
        a_next = a_reg;
        ma_next = ma_reg;
        dq_next = dq_reg;
        dq_oe_next = dq_oe_reg;
        sm_next = sm_reg;
        sm_oe_next = sm_oe_reg;
        rd_take_next = 1'h0;
        wr_word_next = wr_word_reg;
        wr_be_next = wr_be_reg;
        wr_valid_next = 1'h0;
        case (state_reg)
            DS_IDLE: begin
                dq_oe_next = 1'h0;
                sm_oe_next = 1'h0;
                active_next = 1'h0;
                if (lat_done && !sel_s) begin
                    space_next = space_select;
                    zl_next = xfer_write & zero_lat;
                    active_next = 1'h1;
                    sm_next = 1'h0;
                    dq_next = DQ_IDLE;
                    if (xfer_write) begin
                        state_next = DS_WRITE;
                        // Held low rather than floated while no mask comes
                        sm_oe_next = zero_lat;
                    end else begin
                        state_next = DS_READ;
                        dq_oe_next = 1'h1;
                        sm_oe_next = 1'h1;
                    end
                end
            end
            DS_READ: begin
                // The stored word is kept in lane order {A, B}, so memory
                // bytes return where they were written and register words
                // leave upper byte first
                if (rise) begin
                    dq_next = rd_word[WORD_W-1:BYTE_W];
                    b_hold_next = rd_word[BYTE_W-1:0];
                    sm_next = 1'h1;
                end else if (fall) begin
                    dq_next = b_hold_reg;
                    sm_next = 1'h0;
                    rd_take_next = 1'h1;
                end
            end
            DS_WRITE: begin
                if (rise) begin
                    a_next = dq_s;
                    ma_next = sm_s & ~zl_reg;
                end else if (fall) begin
                    // Register words are taken big-endian as {A, B}
                    wr_word_next = {a_reg, dq_s};
                    if (zl_reg) begin
                        wr_be_next = BE_ALL;
                    end else begin
                        wr_be_next = ~{ma_reg, sm_s};
                    end
                    wr_valid_next = 1'h1;
                end
            end
            default: begin
                state_next = DS_IDLE;
                dq_oe_next = 1'h0;
                sm_oe_next = 1'h0;
            end
        endcase
        // Select going high ends the phase at once and frees the lines
        if (sel_s && state_reg != DS_IDLE) begin
            state_next = DS_IDLE;
            dq_oe_next = 1'h0;
            sm_oe_next = 1'h0;
            active_next = 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= DS_IDLE;
            zl_reg <= 1'h0;
            space_reg <= SPACE_MEM;
            active_reg <= 1'h0;
            b_hold_reg <= DQ_IDLE;
            a_reg <= DQ_IDLE;
            ma_reg <= 1'h0;
            dq_reg <= DQ_IDLE;
            dq_oe_reg <= 1'h0;
            sm_reg <= 1'h0;
            sm_oe_reg <= 1'h0;
            rd_take_reg <= 1'h0;
            wr_word_reg <= '0;
            wr_be_reg <= 2'h0;
            wr_valid_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            zl_reg <= zl_next;
            space_reg <= space_next;
            active_reg <= active_next;
            b_hold_reg <= b_hold_next;
            a_reg <= a_next;
            ma_reg <= ma_next;
            dq_reg <= dq_next;
            dq_oe_reg <= dq_oe_next;
            sm_reg <= sm_next;
            sm_oe_reg <= sm_oe_next;
            rd_take_reg <= rd_take_next;
            wr_word_reg <= wr_word_next;
            wr_be_reg <= wr_be_next;
            wr_valid_reg <= wr_valid_next;
        end
    end

    // Link and user outputs straight from flops
    assign link.d_dq = dq_reg;
    assign link.d_dq_oe = dq_oe_reg;
    assign link.d_sm = sm_reg;
    assign link.d_sm_oe = sm_oe_reg;
    assign rd_take = rd_take_reg;
    assign wr_word = wr_word_reg;
    assign wr_be = wr_be_reg;
    assign wr_valid = wr_valid_reg;
    assign reg_space = space_reg;
    assign active = active_reg;
endmodule : dbm_dev

// [hdl/dbm_host.sv]
/*
 Host end of the data phase: makes the bus clock by division of mclk,
 drives write bytes and masks centred on edges, and collects read
 bytes on the device strobe. Assumes the command phase is handled
 outside; start stands for the moment at which the data phase may begin.
*/
`timescale 1ns/1ns
module dbm_host (
    input wire logic mclk,
    input wire logic arst_n,
    dbm_link_if.host link,
    input wire logic start,
    input wire logic op_write,
    input wire logic op_zero_lat,
    input wire logic op_space,
    input wire logic op_le,
    input wire logic [dbm_pkg::CNT_W-1:0] op_words,
    input wire logic [dbm_pkg::WORD_W-1:0] wr_word,
    input wire logic [1:0] wr_mask,
    output logic wr_take,
    output logic [dbm_pkg::WORD_W-1:0] rd_word,
    output logic rd_valid,
    output logic busy
);
    import dbm_pkg::*;

    logic [HOST_SYNC_W-1:0] s1_reg;
    logic [HOST_SYNC_W-1:0] s2_reg;
    logic sm_d_reg;
    logic sm_s;
    logic [BYTE_W-1:0] dq_s;
    logic [WORD_W-1:0] ord;

    dbm_host_state_t state_reg, state_next;
    logic [3:0] half_reg, half_next;
    logic [1:0] pre_reg, pre_next;
    logic [CNT_W-1:0] words_reg, words_next;
    logic [CNT_W-1:0] wcnt_reg, wcnt_next;
    logic swap_reg, swap_next;
    logic wr_reg, wr_next;
    logic [BYTE_W-1:0] b_hold_reg, b_hold_next;
    logic mb_reg, mb_next;
    logic [BYTE_W-1:0] a_in_reg, a_in_next;
    logic clk_reg, clk_next;
    logic sel_n_reg, sel_n_next;
    logic [BYTE_W-1:0] dq_reg, dq_next;
    logic dq_oe_reg, dq_oe_next;
    logic sm_reg, sm_next;
    logic sm_oe_reg, sm_oe_next;
    logic wr_take_reg, wr_take_next;
    logic [WORD_W-1:0] rd_word_reg, rd_word_next;
    logic rd_valid_reg, rd_valid_next;
    logic busy_reg, busy_next;

    // Returned lanes and strobe cross in through two flops together
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            sm_d_reg <= 1'h0;
        end else begin
            s1_reg <= {link.strobe_mask, link.dq};
            s2_reg <= s1_reg;
            sm_d_reg <= s2_reg[BYTE_W];
        end
    end
    assign sm_s = s2_reg[BYTE_W];
    assign dq_s = s2_reg[BYTE_W-1:0];
    // Low byte first only applies to memory space
    assign ord = dbm_order(wr_word, swap_reg);

    always_comb begin
        state_next = state_reg;
        half_next = half_reg;
        pre_next = pre_reg;
        words_next = words_reg;
        wcnt_next = wcnt_reg;
        swap_next = swap_reg;
        wr_next = wr_reg;
        b_hold_next = b_hold_reg;
        mb_next = mb_reg;
        a_in_next = a_in_reg;
        clk_next = clk_reg;
        sel_n_next = sel_n_reg;
        dq_next = dq_reg;
        dq_oe_next = dq_oe_reg;
        sm_next = sm_reg;
        sm_oe_next = sm_oe_reg;
        wr_take_next = 1'h0;
        rd_word_next = rd_word_reg;
        rd_valid_next = 1'h0;
        busy_next = busy_reg;
        // Read bytes follow the strobe: A while high, B while low
        if (!wr_reg && (state_reg == HS_RUN || state_reg == HS_TAIL)) begin
            if (sm_s && !sm_d_reg) begin
                a_in_next = dq_s;
            end else if (!sm_s && sm_d_reg) begin
                rd_word_next = dbm_order({a_in_reg, dq_s}, swap_reg);
                rd_valid_next = 1'h1;
            end
        end
        case (state_reg)
            HS_IDLE: begin
                if (start) begin
                    state_next = HS_PRE;
                    sel_n_next = 1'h0;
                    busy_next = 1'h1;
                    half_next = 4'h0;
                    pre_next = 2'h0;
                    wcnt_next = '0;
                    words_next = op_words;
                    wr_next = op_write;
                    swap_next = op_le & (op_space == SPACE_MEM);
                    dq_oe_next = op_write;
                    dq_next = DQ_IDLE;
                    sm_next = 1'h0;
                    sm_oe_next = op_write & ~op_zero_lat;
                end
            end
            HS_PRE: begin
                half_next = 4'(half_reg + 4'h1);
                if (half_reg == HALF_LAST) begin
                    half_next = 4'h0;
                    pre_next = 2'(pre_reg + 2'h1);
                    if (pre_reg == PRE_LAST) begin
                        state_next = HS_RUN;
                    end
                end
            end
            HS_RUN: begin
                half_next = 4'(half_reg + 4'h1);
                // Lanes move mid-half, four cycles clear of either edge
                if (half_reg == HALF_MID && wr_reg) begin
                    if (!clk_reg) begin
                        dq_next = ord[WORD_W-1:BYTE_W];
                        b_hold_next = ord[BYTE_W-1:0];
                        sm_next = swap_reg ? wr_mask[0] : wr_mask[1];
                        mb_next = swap_reg ? wr_mask[1] : wr_mask[0];
                        wr_take_next = 1'h1;
                    end else begin
                        dq_next = b_hold_reg;
                        sm_next = mb_reg;
                    end
                end
                if (half_reg == HALF_LAST) begin
                    half_next = 4'h0;
                    clk_next = ~clk_reg;
                    if (clk_reg) begin
                        wcnt_next = CNT_W'(wcnt_reg + 1'h1);
                        if (CNT_W'(wcnt_reg + 1'h1) == words_reg) begin
                            state_next = HS_TAIL;
                        end
                    end
                end
            end
            HS_TAIL: begin
                // One idle half lets the last byte land on either end
                half_next = 4'(half_reg + 4'h1);
                if (half_reg == HALF_LAST) begin
                    state_next = HS_END;
                end
            end
            HS_END: begin
                state_next = HS_IDLE;
                sel_n_next = 1'h1;
                dq_oe_next = 1'h0;
                sm_oe_next = 1'h0;
                busy_next = 1'h0;
            end
            default: begin
                state_next = HS_IDLE;
                sel_n_next = 1'h1;
                busy_next = 1'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= HS_IDLE;
            half_reg <= 4'h0;
            pre_reg <= 2'h0;
            words_reg <= '0;
            wcnt_reg <= '0;
            swap_reg <= 1'h0;
            wr_reg <= 1'h0;
            b_hold_reg <= DQ_IDLE;
            mb_reg <= 1'h0;
            a_in_reg <= DQ_IDLE;
            clk_reg <= 1'h0;
            sel_n_reg <= 1'h1;
            dq_reg <= DQ_IDLE;
            dq_oe_reg <= 1'h0;
            sm_reg <= 1'h0;
            sm_oe_reg <= 1'h0;
            wr_take_reg <= 1'h0;
            rd_word_reg <= '0;
            rd_valid_reg <= 1'h0;
            busy_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            half_reg <= half_next;
            pre_reg <= pre_next;
            words_reg <= words_next;
            wcnt_reg <= wcnt_next;
            swap_reg <= swap_next;
            wr_reg <= wr_next;
            b_hold_reg <= b_hold_next;
            mb_reg <= mb_next;
            a_in_reg <= a_in_next;
            clk_reg <= clk_next;
            sel_n_reg <= sel_n_next;
            dq_reg <= dq_next;
            dq_oe_reg <= dq_oe_next;
            sm_reg <= sm_next;
            sm_oe_reg <= sm_oe_next;
            wr_take_reg <= wr_take_next;
            rd_word_reg <= rd_word_next;
            rd_valid_reg <= rd_valid_next;
            busy_reg <= busy_next;
        end
    end

    assign link.bus_clk = clk_reg;
    assign link.sel_n = sel_n_reg;
    assign link.h_dq = dq_reg;
    assign link.h_dq_oe = dq_oe_reg;
    assign link.h_sm = sm_reg;
    assign link.h_sm_oe = sm_oe_reg;
    assign wr_take = wr_take_reg;
    assign rd_word = rd_word_reg;
    assign rd_valid = rd_valid_reg;
    assign busy = busy_reg;
endmodule : dbm_host

// [hdl/dbm_link_if.sv]
/*
 Link between host and device: bus clock, select, eight data lanes and
 the strobe/mask line. Each shared line is resolved here from the two
 drivers and their enables; an undriven line reads low.
*/
`timescale 1ns/1ns
interface dbm_link_if;
    import dbm_pkg::*;
    logic bus_clk;
    logic sel_n;
    logic [BYTE_W-1:0] h_dq;
    logic h_dq_oe;
    logic [BYTE_W-1:0] d_dq;
    logic d_dq_oe;
    logic h_sm;
    logic h_sm_oe;
    logic d_sm;
    logic d_sm_oe;
    logic [BYTE_W-1:0] dq;
    logic strobe_mask;

    // Host wins a clash so that a fault shows as wrong data, not as X
    assign dq = h_dq_oe ? h_dq : (d_dq_oe ? d_dq : DQ_IDLE);
    assign strobe_mask = h_sm_oe ? h_sm : (d_sm_oe & d_sm);

    modport host (
        output bus_clk, sel_n, h_dq, h_dq_oe, h_sm, h_sm_oe,
        input dq, strobe_mask
    );
    modport dev (
        input bus_clk, sel_n, dq, strobe_mask,
        output d_dq, d_dq_oe, d_sm, d_sm_oe
    );
endinterface : dbm_link_if

// [hdl/dbm_pkg.sv]
/*
 Shared constants, state types and the byte ordering helper for both ends
 of the data-phase byte-lane link. Assumes a 100 MHz mclk on both ends
 and a command phase, handled elsewhere, that supplies the space bit and
 the moment at which latency has run out.
*/
// Overview of operation
// - Memory: first byte A, second byte B
// - Memory bytes come back in written lanes
// - Bits high to low; big-endian A=15:8
// - Reads carry two bytes per clock
// - Register read: A=15:8 while strobe high
// - Register read: B=7:0 while strobe low
// - Register write: A on rise, B fall
// - Register data is always big-endian
// - Host centres write data on edges
// - Latency writes: strobe masks each byte
// - Zero-latency writes: host leaves strobe undriven
// - Zero-latency writes store whole words
// - Zero-latency writes: device drives strobe low
// - Mask high keeps byte, low stores
// - Host drives mask low before data
// - Space bit: zero memory, one register
package dbm_pkg;
    localparam int CLK_NS = 10;
    localparam int BUS_CLK_NS = 160;
    // Bus clock half period in mclk cycles, derived from the two rates
    localparam int HALF_CYC = BUS_CLK_NS / (2 * CLK_NS);
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
    localparam logic [3:0] HALF_MID = 4'(HALF_CYC / 2 - 1);
    localparam int PRE_HALVES = 2;
    localparam logic [1:0] PRE_LAST = 2'(PRE_HALVES - 1);
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int CNT_W = 8;
    localparam int CA_SPACE_BIT = 46;
    localparam logic SPACE_MEM = 1'h0;
    localparam logic SPACE_REG = 1'h1;
    localparam logic [BYTE_W-1:0] DQ_IDLE = 8'h00;
    localparam logic [1:0] BE_ALL = 2'h3;
    // Synchroniser widths: device takes bus clock, select, strobe/mask and eight lanes; host takes strobe/mask and eight lanes
    localparam int DEV_SYNC_W = 11;
    localparam int HOST_SYNC_W = 9;

    typedef enum logic [2:0] {
        DS_IDLE = 3'h1,
        DS_READ = 3'h2,
        DS_WRITE = 3'h4
    } dbm_dev_state_t;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_PRE = 5'h02,
        HS_RUN = 5'h04,
        HS_TAIL = 5'h08,
        HS_END = 5'h10
    } dbm_host_state_t;

    // Lane order of a word: {byte A, byte B}; swap gives low byte first
    function automatic logic [WORD_W-1:0] dbm_order(
        input logic [WORD_W-1:0] w,
        input logic swap
    );
        dbm_order = swap ? {w[BYTE_W-1:0], w[WORD_W-1:BYTE_W]} : w;
    endfunction : dbm_order
endpackage : dbm_pkg

// [tb/dbm_link_monitor.sv]
/*
 Checker for the link between the host and device ends: watches the
 resolved and per-end signals of one link interface. Assumes mclk drives
 both ends and that the bench instantiates it beside that interface.
*/
`timescale 1ns/1ns
module dbm_link_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic bus_clk,
    input wire logic sel_n,
    input wire logic [dbm_pkg::BYTE_W-1:0] h_dq,
    input wire logic h_dq_oe,
    input wire logic [dbm_pkg::BYTE_W-1:0] d_dq,
    input wire logic d_dq_oe,
    input wire logic h_sm,
    input wire logic h_sm_oe,
    input wire logic d_sm,
    input wire logic d_sm_oe,
    input wire logic [dbm_pkg::BYTE_W-1:0] dq,
    input wire logic strobe_mask
);
    import dbm_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Read phase: device owns the strobe and the host drives no lanes
    logic rd_ph;
    assign rd_ph = !sel_n && d_sm_oe && !h_dq_oe;

    lane_owner_a: assert property (
        !(h_dq_oe && d_dq_oe)) else $error("both ends drive the lanes");
    zl_strobe_low_a: assert property (
        (h_dq_oe && d_sm_oe) |-> !d_sm) else $error("strobe high on write");
    mask_owner_a: assert property (
        h_sm_oe |-> !d_sm_oe) else $error("mask and strobe both driven");
    mask_preamble_a: assert property (
        $rose(h_sm_oe) |-> !h_sm [*8]) else $error("mask preamble not low");
    centre_data_a: assert property (
        (h_dq_oe && $changed(bus_clk)) |-> $stable(h_dq) ##1 $stable(h_dq))
        else $error("write lanes move near a bus clock edge");
    rd_strobe_high_a: assert property (
        (rd_ph && $rose(bus_clk)) |-> ##[1:5] d_sm)
        else $error("no strobe rise for byte A");
    rd_strobe_low_a: assert property (
        (rd_ph && $fell(bus_clk)) |-> ##[1:5] !d_sm)
        else $error("no strobe fall for byte B");
    idle_clock_a: assert property (
        sel_n |-> !bus_clk) else $error("bus clock high while deselected");
    release_lines_a: assert property (
        $rose(sel_n) |-> (!h_dq_oe && !h_sm_oe)
        ##[1:5] (!d_dq_oe && !d_sm_oe)) else $error("lines held after end");

    cover property ($rose(h_sm_oe));
    cover property (rd_ph && $fell(bus_clk));
    cover property (h_dq_oe && d_sm_oe && $rose(bus_clk));
endmodule : dbm_link_monitor

// [tb/ddr_data_phase_byte_lane_mapper_bench.sv]
/*
 Bench for the byte-lane link: host and device ends joined by one link,
 one- and two-word transfers driven from both user sides. Assumes no command
 phase; the bench pulses lat_done in its place.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module ddr_data_phase_byte_lane_mapper_bench;
    import dbm_pkg::*;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic start = 1'h0;
    logic op_write = 1'h0;
    logic op_zl = 1'h0;
    logic op_space = 1'h0;
    logic op_le = 1'h0;
    logic lat_done = 1'h0;
    logic [15:0] h_wr_word = 16'h0000;
    logic [1:0] h_wr_mask = 2'h0;
    logic [15:0] d_rd_word = 16'h0000;
    logic h_wr_take, h_rd_valid, h_busy, d_rd_take, d_wr_valid;
    logic d_reg_space, d_active;
    logic [15:0] h_rd_word, d_wr_word;
    logic [1:0] d_wr_be;
    logic [7:0] wire_a = 8'h00;
    logic [7:0] wire_b = 8'h00;
    int num_errors = 0;
    int n_checks = 0;
    int n_wt = 0;
    int n_rt = 0;
    logic [7:0] op_n = 8'h01;

    dbm_link_if dbm_link_if_i ();
    dbm_host dbm_host_i (.mclk(mclk), .arst_n(arst_n),
        .link(dbm_link_if_i), .start(start), .op_write(op_write),
        .op_zero_lat(op_zl), .op_space(op_space), .op_le(op_le),
        .op_words(op_n), .wr_word(h_wr_word), .wr_mask(h_wr_mask),
        .wr_take(h_wr_take), .rd_word(h_rd_word), .rd_valid(h_rd_valid),
        .busy(h_busy));
    dbm_dev dbm_dev_i (.mclk(mclk), .arst_n(arst_n), .link(dbm_link_if_i),
        .lat_done(lat_done), .xfer_write(op_write), .zero_lat(op_zl),
        .space_select(op_space), .rd_word(d_rd_word), .rd_take(d_rd_take),
        .wr_word(d_wr_word), .wr_be(d_wr_be), .wr_valid(d_wr_valid),
        .reg_space(d_reg_space), .active(d_active));
    dbm_link_monitor dbm_link_monitor_i (.mclk(mclk), .arst_n(arst_n),
        .bus_clk(dbm_link_if_i.bus_clk), .sel_n(dbm_link_if_i.sel_n),
        .h_dq(dbm_link_if_i.h_dq), .h_dq_oe(dbm_link_if_i.h_dq_oe),
        .d_dq(dbm_link_if_i.d_dq), .d_dq_oe(dbm_link_if_i.d_dq_oe),
        .h_sm(dbm_link_if_i.h_sm), .h_sm_oe(dbm_link_if_i.h_sm_oe),
        .d_sm(dbm_link_if_i.d_sm), .d_sm_oe(dbm_link_if_i.d_sm_oe),
        .dq(dbm_link_if_i.dq), .strobe_mask(dbm_link_if_i.strobe_mask));

    // Clock at 100 MHz
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Lanes as the far end sees them: byte A on rise, byte B on fall
    always @(posedge dbm_link_if_i.bus_clk) begin
        if (dbm_link_if_i.h_dq_oe) wire_a = dbm_link_if_i.dq;
    end
    always @(negedge dbm_link_if_i.bus_clk) begin
        if (dbm_link_if_i.h_dq_oe) wire_b = dbm_link_if_i.dq;
    end

    // Word takes on both user sides, cleared by each start
    always @(posedge mclk) begin
        if (start) begin
            n_wt <= 0;
            n_rt <= 0;
        end else begin
            n_wt <= n_wt + int'(h_wr_take);
            n_rt <= n_rt + int'(d_rd_take);
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Transfer of op_n words; d feeds both the host write and the device read
    task automatic xfer(input logic w, input logic zl, input logic sp,
        input logic le, input logic [15:0] d, input logic [1:0] m,
        input logic [15:0] e, input logic [1:0] be);
        int n;
        @(negedge mclk);
        op_write = w;
        op_zl = zl;
        op_space = sp;
        op_le = le;
        h_wr_word = d;
        h_wr_mask = m;
        d_rd_word = d;
        start = 1'h1;
        @(negedge mclk);
        start = 1'h0;
        // Device must see select low through its synchroniser first
        n = 0;
        while (dbm_link_if_i.sel_n !== 1'h0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 50) num_errors++;
        repeat (4) @(negedge mclk);
        lat_done = 1'h1;
        @(negedge mclk);
        lat_done = 1'h0;
        n = 0;
        while ((w ? d_wr_valid : h_rd_valid) !== 1'h1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        // A lost word would leave the previous result standing
        if (n >= 100) num_errors++;
        if (w) begin
            `CHK(d_wr_word, e)
            `CHK(d_wr_be, be)
        end else begin
            `CHK(h_rd_word, e)
        end
        `CHK(d_reg_space, sp)
        n = 0;
        while ((h_busy | d_active) !== 1'h0 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 100) num_errors++;
        if (w) `CHK({wire_a, wire_b}, e)
        // One take per word, only on the side that supplies the data
        `CHK(n_wt, w ? op_n : 8'h00)
        `CHK(n_rt, w ? 8'h00 : op_n)
        repeat (3) @(negedge mclk);
        $display("test done: write %0d space %0d le %0d", w, sp, le);
    endtask : xfer

    // Hang guard: ten transfers take well under 1000 cycles
    initial begin
        #20000;
        num_errors++;
        results();
    end

    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'h1;
        repeat (2) @(negedge mclk);
        xfer(1, 0, 0, 0, 16'h1234, 2'h0, 16'h1234, 2'h3);
        xfer(1, 0, 0, 1, 16'h1234, 2'h1, 16'h3412, 2'h1);
        xfer(1, 0, 0, 0, 16'h5aa5, 2'h2, 16'h5aa5, 2'h1);
        xfer(1, 1, 0, 0, 16'hc33c, 2'h3, 16'hc33c, 2'h3);
        xfer(1, 0, 1, 1, 16'hbeef, 2'h0, 16'hbeef, 2'h3);
        xfer(0, 0, 0, 0, 16'hc3a5, 2'h0, 16'hc3a5, 2'h0);
        xfer(0, 0, 0, 1, 16'h3412, 2'h0, 16'h1234, 2'h0);
        xfer(0, 0, 1, 1, 16'h8001, 2'h0, 16'h8001, 2'h0);
        // Two-word bursts: one word per bus clock cycle each way
        op_n = 8'h02;
        xfer(1, 0, 0, 0, 16'ha55a, 2'h0, 16'ha55a, 2'h3);
        xfer(0, 0, 0, 0, 16'h5aa5, 2'h0, 16'h5aa5, 2'h0);
        results();
    end
endmodule : ddr_data_phase_byte_lane_mapper_bench
